// [core/apd_pkg.sv]
// Package of constants for the automatic power-down and power mode logic.
// Assumes a single 200 MHz clock and an 8-bit register port with byte offsets.
//
// Summary of operation
// - With the unit enabled and strobe idle, a four-bit idle counter advances per input clock.
// - Fifteen idle input clock periods raise the power-down flag and enter power-down.
// - Setting the unit enable bit alone enables power-down mode.
// - Strobe pulses, module select low or warm reset high leave power-down.
// - In power-down the bus is blocked from memories and both logic arrays; memories deselected.
// - Gating the input clock from the arrays never gates it from the idle counter.
// - In power-down memories go standby; logic arrays and I/O blocks stay active.
// - In power-down MCU I/O and array outputs hold, address out undefined, peripherals tri-state.
// - Select low enables flash, SRAM and I/O; high disables flash, SRAM and I/O.
// - Select never blocks array signals; first access after selection may be slower.
// - Control A bit 3 picks full power at 0, low power at 1; default full.
// - Control A bits 4 and 5 gate the input clock from AND array and macrocells.
// - Each memory stays standby while inputs are stable, wakes one cycle on a change.
// - Software may write the mode registers any time; blocking bits gate both arrays.
// - Control B bits 2 to 5 gate write, read, program read and address strobe from the array.
// - Both mode registers clear only on power-up reset, never on warm reset.
package apd_pkg;

  // ---------------------------------------------------------------
  // Register port geometry and offsets
  // ---------------------------------------------------------------
  localparam int         REG_ADDR_W      = 8;
  localparam int         REG_DATA_W      = 8;
  localparam logic [7:0] OFS_MODE_A      = 8'h00;
  localparam logic [7:0] OFS_MODE_B      = 8'h01;
  localparam logic [7:0] OFS_APD_CTRL    = 8'h02;
  localparam logic [7:0] OFS_APD_STATUS  = 8'h03;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int BIT_A_LOW_POWER   = 3;
  localparam int BIT_A_CLK_ARRAY   = 4;
  localparam int BIT_A_CLK_MCELL   = 5;
  localparam int BIT_B_WR          = 2;
  localparam int BIT_B_RD          = 3;
  localparam int BIT_B_PROGRAM_READ_STROBE        = 4;
  localparam int BIT_B_STROBE      = 5;
  localparam int BIT_CTRL_ENABLE   = 0;
  localparam int BIT_STAT_PD       = 0;
  localparam int BIT_STAT_COUNTING = 1;
  localparam int STAT_COUNT_LSB    = 4;

  // Writable bits; unused bits read as zero
  localparam logic [7:0] MASK_MODE_A   = 8'h38;
  localparam logic [7:0] MASK_MODE_B   = 8'h3C;
  localparam logic [7:0] MASK_CTRL     = 8'h01;

  // ---------------------------------------------------------------
  // Reset values and timing counts
  // ---------------------------------------------------------------
  localparam logic [7:0] RESET_MODE    = 8'h00;
  localparam logic [7:0] RESET_CTRL    = 8'h00;
  localparam int         IDLE_CNT_W    = 4;
  localparam int         IDLE_PERIODS  = 15;
  localparam int         MEM_COUNT     = 3;

endpackage

// [core/rise_detect.sv]
// Rising edge detector for a group of clock-synchronous inputs.
// Assumes inputs already change only on the system clock.
module rise_detect #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise
);
  logic [WIDTH-1:0] prev;

  // Previous sample of each input
  always_ff @(posedge clk) begin
    if (!nrst) begin
      prev <= '0;
    end else begin
      prev <= level;
    end
  end

  assign rise = level & ~prev;
endmodule

// [core/apd_idle_counter.sv]
// Idle counter of the automatic power-down unit.
// Assumes tick is a one-cycle pulse per input clock period, never gated.
module apd_idle_counter
  import apd_pkg::*;
#(
  parameter int LIMIT = IDLE_PERIODS
) (
  input  wire logic                  clk,
  input  wire logic                  nrst,
  input  wire logic                  enable,
  input  wire logic                  strobe_pulse,
  input  wire logic                  wake,
  input  wire logic                  tick,
  output logic      [IDLE_CNT_W-1:0] count,
  output logic                       powerdown
);
  localparam logic [IDLE_CNT_W-1:0] LAST = IDLE_CNT_W'(LIMIT - 1);

  wire clear   = !enable || strobe_pulse || wake;
  wire advance = tick && !powerdown;

  // Count idle periods, flag power-down on the last one
  always_ff @(posedge clk) begin
    if (!nrst || clear) begin
      count     <= '0;
      powerdown <= 1'b0;
    end else if (advance) begin
      count <= count + 1'b1;
      if (count == LAST) begin
        powerdown <= 1'b1;
      end
    end
  end
endmodule

// [core/apd_power_ctrl.sv]
// Top of the automatic power-down and power mode logic.
// Assumes all pins are synchronous to clk; nrst is the power-up reset,
// warm_reset the running reset pin; the register port never waits.
module apd_power_ctrl
  import apd_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 8,
  parameter int IDLE_COUNT = apd_pkg::IDLE_PERIODS
) (
  input  wire logic                           clk,
  input  wire logic                           nrst,
  // Register port
  input  wire logic [apd_pkg::REG_ADDR_W-1:0] reg_addr,
  input  wire logic [apd_pkg::REG_DATA_W-1:0] reg_wdata,
  input  wire logic                           reg_wr,
  input  wire logic                           reg_rd,
  output logic      [apd_pkg::REG_DATA_W-1:0] reg_rdata,
  // Pins and MCU bus
  input  wire logic                           warm_reset,
  input  wire logic                           module_input_clock,
  input  wire logic                           module_select_n,
  input  wire logic                           address_strobe_alt,
  input  wire logic                           mcu_wr_n,
  input  wire logic                           mcu_rd_n,
  input  wire logic                           program_read_strobe,
  input  wire logic [ADDR_W-1:0]              mcu_addr,
  input  wire logic [DATA_W-1:0]              mcu_data,
  input  wire logic                           periph_oe_req,
  // Power state
  output logic                                powerdown_flag,
  // Memory side
  output logic      [ADDR_W-1:0]              mem_addr,
  output logic      [DATA_W-1:0]              mem_data,
  output logic                                flash_a_select,
  output logic                                flash_b_select,
  output logic                                sram_select,
  output logic                                io_block_select,
  output logic      [apd_pkg::MEM_COUNT-1:0]  mem_standby,
  output logic                                mem_slow_access,
  // Logic array side
  output logic      [ADDR_W-1:0]              array_addr,
  output logic      [DATA_W-1:0]              array_data,
  output logic                                array_wr_n,
  output logic                                array_rd_n,
  output logic                                array_program_read_strobe,
  output logic                                array_strobe,
  output logic                                array_and_clock,
  output logic                                macrocell_clock,
  output logic                                array_low_power,
  output logic                                array_active,
  // Port behaviour
  output logic                                io_hold,
  output logic                                addr_out_defined,
  output logic                                periph_oe
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  // The idle counter is four bits wide, so it cannot count past fifteen
  if (IDLE_COUNT < 1 || IDLE_COUNT > (1 << IDLE_CNT_W) - 1) begin : g_bad_count
    $error("IDLE_COUNT must fit the four-bit idle counter");
  end
  if (ADDR_W < 1 || DATA_W < 1) begin : g_bad_width
    $error("bus widths must be positive");
  end

  // ---------------------------------------------------------------
  // Notes for users
  // ---------------------------------------------------------------
  // Clock pin is sampled by clk: keep it
  // below half the clk rate or ticks alias.

  // Outputs trail inputs by one clk; the
  // flag trails the internal state by one more.

  // Wake causes act at once, so a strobe edge
  // in a tick cycle always wins over the count.

  // Mode registers survive the warm reset pin;
  // the control register does not, so the unit
  // is off after any reset until re-enabled.

  // Blocked bus copies freeze, not zero, so no
  // false transition wakes a memory.

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [7:0] mode_a;
  logic [7:0] mode_b;
  logic [7:0] apd_ctrl;
  logic [IDLE_CNT_W-1:0] idle_count;
  logic pd;
  // Unit enable, read by status and idle counter
  wire  apd_enable = apd_ctrl[BIT_CTRL_ENABLE];

  // Address decode
  wire hit_a    = (reg_addr == OFS_MODE_A);
  wire hit_b    = (reg_addr == OFS_MODE_B);
  wire hit_ctrl = (reg_addr == OFS_APD_CTRL);
  wire hit_stat = (reg_addr == OFS_APD_STATUS);

  // Mode registers: only the power-up reset clears them, the warm
  // reset pin deliberately does not, so settings survive it
  always_ff @(posedge clk) begin
    if (!nrst) begin
      mode_a <= RESET_MODE;
      mode_b <= RESET_MODE;
    end else if (reg_wr) begin
      if (hit_a) begin
        mode_a <= reg_wdata & MASK_MODE_A;
      end
      if (hit_b) begin
        mode_b <= reg_wdata & MASK_MODE_B;
      end
    end
  end

  // Unit enable: cleared by either reset, unlike the mode registers
  always_ff @(posedge clk) begin
    if (!nrst || warm_reset) begin
      apd_ctrl <= RESET_CTRL;
    end else if (reg_wr && hit_ctrl) begin
      apd_ctrl <= reg_wdata & MASK_CTRL;
    end
  end

  // Read mux; unmapped offsets read zero
  logic [7:0] status_word;
  logic [7:0] read_mux;
  always_comb begin
    status_word = 8'h00;
    status_word[BIT_STAT_PD] = pd;
    status_word[BIT_STAT_COUNTING] = apd_enable && !pd && idle_count != '0;
    status_word[STAT_COUNT_LSB +: IDLE_CNT_W] = idle_count;
  end
  assign read_mux = hit_a    ? mode_a :
                    hit_b    ? mode_b :
                    hit_ctrl ? apd_ctrl :
                    hit_stat ? status_word : 8'h00;

  // Read data stands the cycle after the strobe only
  always_ff @(posedge clk) begin
    if (!nrst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? read_mux : '0;
    end
  end

  // ---------------------------------------------------------------
  // Edge detection and idle counting
  // ---------------------------------------------------------------
  wire [1:0] edges;

  // Detector starts low, the idle level of
  // both pins, so reset makes no false edge.

  // Raw clock pin feeds the counter before any gating
  rise_detect #(
    .WIDTH (2)
  ) u_edges (
    .clk   (clk),
    .nrst  (nrst),
    .level ({address_strobe_alt, module_input_clock}),
    .rise  (edges)
  );

  wire clk_tick     = edges[0];
  wire strobe_pulse = edges[1];
  // Select low or warm reset forces normal operation
  wire wake         = !module_select_n || warm_reset;

  // No separate power-down enable: unit enable is enough
  apd_idle_counter #(
    .LIMIT (IDLE_COUNT)
  ) u_idle (
    .clk          (clk),
    .nrst         (nrst),
    .enable       (apd_enable),
    .strobe_pulse (strobe_pulse),
    .wake         (wake),
    .tick         (clk_tick),
    .count        (idle_count),
    .powerdown    (pd)
  );

  // ---------------------------------------------------------------
  // Bus blocking and memory selection
  // ---------------------------------------------------------------
  // Power-down freezes the copies and drops
  // the flash and SRAM selects; select high alone deselects
  // memories and I/O but leaves arrays running.

  // Select state and memory wake detection
  logic select_prev;
  logic [ADDR_W-1:0] addr_prev;
  logic [DATA_W-1:0] data_prev;
  wire  selected    = !module_select_n;
  wire  bus_changed = (mcu_addr != addr_prev) || (mcu_data != data_prev);
  wire  mem_enable  = selected && !pd;
  wire  [MEM_COUNT-1:0] mem_sel = {MEM_COUNT{mem_enable}};

  always_ff @(posedge clk) begin
    if (!nrst) begin
      select_prev <= 1'b0;
      addr_prev   <= '0;
      data_prev   <= '0;
    end else begin
      select_prev <= selected;
      addr_prev   <= mcu_addr;
      data_prev   <= mcu_data;
    end
  end

  // Memory bus frozen in power-down so stray bus toggling cannot wake it
  always_ff @(posedge clk) begin
    if (!nrst) begin
      mem_addr <= '0;
      mem_data <= '0;
    end else if (!pd) begin
      mem_addr <= mcu_addr;
      mem_data <= mcu_data;
    end
  end

  // Chip selects; I/O block follows select only, never power-down
  always_ff @(posedge clk) begin
    if (!nrst) begin
      flash_a_select  <= 1'b0;
      flash_b_select  <= 1'b0;
      sram_select     <= 1'b0;
      io_block_select <= 1'b0;
      mem_slow_access <= 1'b0;
    end else begin
      flash_a_select  <= mem_enable;
      flash_b_select  <= mem_enable;
      sram_select     <= mem_enable;
      io_block_select <= selected;
      mem_slow_access <= selected && !select_prev;
    end
  end

  // Each memory wakes only for a cycle when its inputs move
  for (genvar m = 0; m < MEM_COUNT; m++) begin : g_mem_standby
    always_ff @(posedge clk) begin
      if (!nrst) begin
        mem_standby[m] <= 1'b1;
      end else begin
        mem_standby[m] <= !(mem_sel[m] && bus_changed);
      end
    end
  end

  // ---------------------------------------------------------------
  // Logic array inputs
  // ---------------------------------------------------------------
  // Gating acts one cycle after the write,
  // as every array input is registered.

  // Blocked inputs rest at their idle level so the array stays quiet
  wire gate_wr     = mode_b[BIT_B_WR];
  wire gate_rd     = mode_b[BIT_B_RD];
  wire gate_program_read_strobe   = mode_b[BIT_B_PROGRAM_READ_STROBE];
  wire gate_strobe = mode_b[BIT_B_STROBE];
  wire gate_and    = mode_a[BIT_A_CLK_ARRAY];
  wire gate_mcell  = mode_a[BIT_A_CLK_MCELL];

  // Select is deliberately not part of any gating term
  always_ff @(posedge clk) begin
    if (!nrst) begin
      array_wr_n      <= 1'b1;
      array_rd_n      <= 1'b1;
      array_program_read_strobe      <= 1'b0;
      array_strobe    <= 1'b0;
      array_and_clock <= 1'b0;
      macrocell_clock <= 1'b0;
    end else begin
      array_wr_n      <= gate_wr     ? 1'b1 : mcu_wr_n;
      array_rd_n      <= gate_rd     ? 1'b1 : mcu_rd_n;
      array_program_read_strobe      <= gate_program_read_strobe   ? 1'b0 : program_read_strobe;
      array_strobe    <= gate_strobe ? 1'b0 : address_strobe_alt;
      array_and_clock <= gate_and    ? 1'b0 : module_input_clock;
      macrocell_clock <= gate_mcell  ? 1'b0 : module_input_clock;
    end
  end

  // Array address and data are blocked in power-down
  always_ff @(posedge clk) begin
    if (!nrst) begin
      array_addr <= '0;
      array_data <= '0;
    end else if (!pd) begin
      array_addr <= mcu_addr;
      array_data <= mcu_data;
    end
  end

  // ---------------------------------------------------------------
  // Power state and port behaviour
  // ---------------------------------------------------------------
  // Arrays never sleep here, so their outputs
  // can change at once when an input moves.

  // Low power trades array speed for current; default is full power
  always_ff @(posedge clk) begin
    if (!nrst) begin
      powerdown_flag   <= 1'b0;
      array_low_power  <= 1'b0;
      array_active     <= 1'b1;
      io_hold          <= 1'b0;
      addr_out_defined <= 1'b1;
      periph_oe        <= 1'b0;
    end else begin
      powerdown_flag   <= pd;
      array_low_power  <= mode_a[BIT_A_LOW_POWER];
      array_active     <= 1'b1;
      io_hold          <= pd;
      addr_out_defined <= !pd;
      periph_oe        <= periph_oe_req && !pd;
    end
  end

endmodule

// [verif/mcu_bus_model.sv]
// MCU core bus model: address strobe, address and data lines.
// Assumes the system clock; active picks a pulsing or a released bus.
module mcu_bus_model (
  input  wire logic        clk,
  input  wire logic        active,
  output logic             strobe,
  output logic [15:0]      addr,
  output logic [7:0]       data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] phase = 2'h0;
  // ---------------------------------------------------------------
  // Bus cycles
  // ---------------------------------------------------------------
  initial begin
    strobe = 1'b0;
    addr = 16'h0000;
    data = 8'h00;
  end
  // Released lines flip every cycle, so a stale copy never passes as held
  always @(posedge clk) begin
    phase  <= phase + 2'h1;
    strobe <= active && (phase == 2'h0);
    if (!active) begin
      addr <= ~addr;
      data <= ~data;
    end else if (phase == 2'h0) begin
      addr <= addr + 16'h0101;
      data <= data + 8'h11;
    end
  end
endmodule

// [verif/apd_power_ctrl_props.sv]
// Checker for the power-down and select behaviour at the top ports.
// Assumes one clock domain and nrst as its synchronous reset.
module apd_power_ctrl_props
  import apd_pkg::*;
#(
  parameter int ADDR_W     = 16,
  parameter int IDLE_COUNT = 15
) (
  input wire logic                          clk,
  input wire logic                          nrst,
  input wire logic                          warm_reset,
  input wire logic                          module_input_clock,
  input wire logic                          module_select_n,
  input wire logic                          address_strobe_alt,
  input wire logic                          powerdown_flag,
  input wire logic [ADDR_W-1:0]             mem_addr,
  input wire logic                          flash_a_select,
  input wire logic                          flash_b_select,
  input wire logic                          sram_select,
  input wire logic                          io_block_select,
  input wire logic [apd_pkg::MEM_COUNT-1:0] mem_standby,
  input wire logic                          mem_slow_access,
  input wire logic                          array_active,
  input wire logic                          io_hold,
  input wire logic                          addr_out_defined,
  input wire logic                          periph_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ticks;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // ---------------------------------------------------------------
  // Helper: clock pin rises since last bus activity or wake cause
  // ---------------------------------------------------------------
  // Clears on strobe level, which errs toward counting fewer, never more
  always_ff @(posedge clk) begin
    if (!nrst || address_strobe_alt || !module_select_n || warm_reset) begin
      ticks <= 8'h00;
    end else if ($rose(module_input_clock) && ticks != 8'hFF) begin
      ticks <= ticks + 8'h01;
    end
  end
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  sequence wake_seen;
    powerdown_flag && ($rose(address_strobe_alt) || !module_select_n || warm_reset);
  endsequence
  sequence flag_drops;
    ##[1:4] !powerdown_flag;
  endsequence
  pd_exit_a: assert property (wake_seen |-> flag_drops)
    else $error("power-down not left after wake");
  pd_idle_count_a: assert property ($rose(powerdown_flag) |-> ticks >= IDLE_COUNT)
    else $error("power-down entered too early");
  pd_mem_block_a: assert property (powerdown_flag |-> !flash_a_select && !sram_select && $stable(mem_addr))
    else $error("memories reached in power-down");
  pd_port_state_a: assert property (io_hold == powerdown_flag && addr_out_defined == !powerdown_flag
    && !(powerdown_flag && periph_oe)) else $error("port state wrong");
  pd_standby_a: assert property (powerdown_flag && $past(powerdown_flag) |-> mem_standby == 3'h7 && array_active)
    else $error("standby state wrong");
  sel_io_path_a: assert property (io_block_select == !$past(module_select_n))
    else $error("io select not following pin");
  sel_deselect_a: assert property (module_select_n |=> !flash_a_select && !flash_b_select && !sram_select)
    else $error("memory selected while pin high");
  sel_slow_a: assert property ($fell(module_select_n) |-> ##[1:2] mem_slow_access)
    else $error("no slow first access");
endmodule

bind apd_power_ctrl apd_power_ctrl_props #(
  .ADDR_W(ADDR_W),
  .IDLE_COUNT(IDLE_COUNT)
) u_props (.*);

// [verif/test_auto_power_down_control.sv]
// Testbench for the automatic power-down and power mode logic.
// Assumes the package, design, bus model and checker are compiled first.
module test_auto_power_down_control;
  timeunit 1ns;
  timeprecision 1ps;
  import apd_pkg::*;
  localparam int IDLE = 3;
  logic        clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, warm_reset = 1'b0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, mcu_data;
  logic        module_input_clock = 1'b0, module_select_n = 1'b1, bus_active = 1'b1;
  logic        mcu_wr_n = 1'b1, mcu_rd_n = 1'b1, program_read_strobe = 1'b0, periph_oe_req = 1'b1;
  logic [1:0]  div = 2'h0;
  logic [15:0] mcu_addr, mem_addr, array_addr;
  logic [7:0]  mem_data, array_data;
  logic [2:0]  mem_standby;
  logic address_strobe_alt, powerdown_flag, flash_a_select, flash_b_select, sram_select;
  logic io_block_select, mem_slow_access, array_wr_n, array_rd_n, array_program_read_strobe, array_strobe;
  logic array_and_clock, macrocell_clock, array_low_power, array_active, io_hold, addr_out_defined, periph_oe;
  int miscompares = 0;
  int check_count = 0;
  apd_power_ctrl #(.IDLE_COUNT(IDLE)) u_dut (.*);
  mcu_bus_model u_bus (.clk(clk), .active(bus_active), .strobe(address_strobe_alt), .addr(mcu_addr),
    .data(mcu_data));
  // ---------------------------------------------------------------
  // Clocks: 200 MHz system clock, clock pin at a quarter of it
  // ---------------------------------------------------------------
  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    div <= div + 2'h1;
    module_input_clock <= div[1];
  end
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // Bounded wait, so a stuck flag ends as a miscompare, not a hang
  task automatic wait_pd(input logic v, output int n);
    n = 0;
    while (powerdown_flag !== v && n < 80) begin
      cyc(1);
      n++;
    end
    chk(powerdown_flag, v);
  endtask
  task automatic enter_pd();
    int n;
    bus_active <= 1'b0;
    wr(OFS_APD_CTRL, 8'h01);
    wait_pd(1'b1, n);
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    logic [7:0] d;
    for (int i = 0; i < 4; i++) begin
      rd(8'(i), d);
      chk(d, 8'h00);
    end
    chk(array_low_power, 1'b0);
    wr(OFS_MODE_A, 8'hFF);
    rd(OFS_MODE_A, d);
    chk(d, MASK_MODE_A);
    wr(OFS_MODE_B, 8'hFF);
    rd(OFS_MODE_B, d);
    chk(d, MASK_MODE_B);
    wr(8'h10, 8'hFF);
    rd(8'h10, d);
    chk(d, 8'h00);
  endtask
  task automatic t_gates();
    logic [1:0] seen;
    wr(OFS_MODE_A, 8'h38);
    wr(OFS_MODE_B, 8'h3C);
    mcu_wr_n <= 1'b0;
    mcu_rd_n <= 1'b0;
    program_read_strobe <= 1'b1;
    cyc(2);
    chk(array_low_power, 1'b1);
    seen = 2'h0;
    repeat (8) begin
      cyc(1);
      seen[0] |= array_and_clock | macrocell_clock | array_strobe | array_program_read_strobe | !array_wr_n | !array_rd_n;
    end
    chk(seen, 2'h0);
    wr(OFS_MODE_A, 8'h00);
    wr(OFS_MODE_B, 8'h00);
    cyc(2);
    chk({array_wr_n, array_rd_n, array_program_read_strobe}, 3'h1);
    repeat (8) begin
      cyc(1);
      seen[0] |= array_and_clock & macrocell_clock;
      seen[1] |= array_strobe;
    end
    chk(seen, 2'h3);
    mcu_wr_n <= 1'b1;
    mcu_rd_n <= 1'b1;
    program_read_strobe <= 1'b0;
  endtask
  task automatic t_select();
    logic [15:0] held;
    logic slow;
    int lo;
    chk({flash_a_select, flash_b_select, sram_select, io_block_select}, 4'h0);
    held = array_addr;
    cyc(4);
    chk(array_addr !== held, 1'b1);
    module_select_n <= 1'b0;
    slow = 1'b0;
    repeat (3) begin
      cyc(1);
      slow |= mem_slow_access;
    end
    chk(slow, 1'b1);
    chk({flash_a_select, flash_b_select, sram_select, io_block_select}, 4'hF);
    lo = 0;
    repeat (8) begin
      cyc(1);
      lo += (mem_standby !== 3'h7);
    end
    chk(lo > 0 && lo < 8, 1'b1);
    module_select_n <= 1'b1;
  endtask
  task automatic t_apd();
    logic [7:0] d;
    logic [15:0] held;
    logic [15:0] held_aa;
    logic [7:0]  held_d, held_a;
    int n;
    wr(OFS_MODE_A, 8'h30);
    bus_active <= 1'b0;
    wr(OFS_APD_CTRL, 8'h01);
    wait_pd(1'b1, n);
    chk(n >= 4 * (IDLE - 1) && n <= 4 * IDLE + 4, 1'b1);
    rd(OFS_APD_STATUS, d);
    chk(d[BIT_STAT_PD], 1'b1);
    held = mem_addr;
    held_d = mem_data;
    held_aa = array_addr;
    held_a = array_data;
    cyc(6);
    chk(mem_addr, held);
    chk({mem_data, array_addr, array_data}, {held_d, held_aa, held_a});
    chk({flash_a_select, flash_b_select, sram_select, periph_oe}, 4'h0);
    chk({io_hold, addr_out_defined, mem_standby, array_active}, 6'h2F);
    bus_active <= 1'b1;
    wait_pd(1'b0, n);
  endtask
  task automatic t_exits();
    logic [7:0] d;
    int n;
    wr(OFS_MODE_A, 8'h08);
    enter_pd();
    module_select_n <= 1'b0;
    wait_pd(1'b0, n);
    module_select_n <= 1'b1;
    enter_pd();
    warm_reset <= 1'b1;
    cyc(2);
    warm_reset <= 1'b0;
    wait_pd(1'b0, n);
    rd(OFS_MODE_A, d);
    chk(d, 8'h08);
    rd(OFS_APD_CTRL, d);
    chk(d, 8'h00);
  endtask
  // ---------------------------------------------------------------
  // Sequence, watchdog and verdict
  // ---------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_gates();
    t_select();
    t_apd();
    t_exits();
    stop_test();
  end
  // Whole run is under a thousand cycles; this margin only catches a hang
  initial begin
    #20us;
    miscompares++;
    stop_test();
  end
endmodule
